//--- test/uefa_sie_model.sv
// Behavioural model of the serial engine on the packet side of the FIFO block.
// Assumes the bench calls its tasks right after a rising edge of core_clk.

`timescale 1ns/100ps
`default_nettype none

module uefa_sie_model
    import uefa_pkg::*;
(
    input  wire logic                core_clk,
    output logic                     sieRxValid,
    output logic      [EP_IDX_W-1:0] sieRxEp,
    output logic      [7:0]          sieRxData,
    input  wire logic                sieRxReady,
    output logic                     sieTxReq,
    output logic      [EP_IDX_W-1:0] sieTxEp,
    input  wire logic                sieTxValid,
    input  wire logic [7:0]          sieTxData
);
    // ------------------------------------------------------------
    // Idle state of the engine lines
    // ------------------------------------------------------------
    initial begin
        sieRxValid = 1'b0;
        sieRxEp    = 3'h0;
        sieRxData  = 8'h5A;
        sieTxReq   = 1'b0;
        sieTxEp    = 3'h0;
    end

    // Offer one byte, held until taken; slow mode idles first
    // No cycle limit here: a hang is ended by the bench watchdog
    task automatic sendByte(input logic [2:0] ep, input logic [7:0] data, input bit slow);
        if (slow) begin
            sieRxValid <= 1'b0;
            sieRxData  <= ~sieRxData;
            repeat (1 + $urandom_range(2)) @(posedge core_clk);
        end
        sieRxValid <= 1'b1;
        sieRxEp    <= ep;
        sieRxData  <= data;
        do begin
            @(posedge core_clk);
        end while (sieRxReady !== 1'b1);
    endtask

    // Released lines show the inverse so stale data never looks valid
    task automatic rxRelease();
        sieRxValid <= 1'b0;
        sieRxEp    <= ~sieRxEp;
        sieRxData  <= ~sieRxData;
    endtask

    // Ask one byte; the engine knows how many are there, no empty check
    task automatic fetchByte(input logic [2:0] ep, output logic [7:0] data);
        sieTxReq <= 1'b1;
        sieTxEp  <= ep;
        @(posedge core_clk);
        sieTxReq <= 1'b0;
        do begin
            @(posedge core_clk);
        end while (sieTxValid !== 1'b1);
        data = sieTxData;
    endtask
endmodule

`default_nettype wire

//--- test/usb_endpoint_fifo_access_test.sv
// Self-checking bench for the endpoint FIFO access block.
// Assumes the engine model in uefa_sie_model and AHB-Lite single word transfers.

`timescale 1ns/100ps
`default_nettype none

module usb_endpoint_fifo_access_test
    import uefa_pkg::*;
;
    logic                core_clk;
    logic                rst_b;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic                sieRxValid;
    logic [EP_IDX_W-1:0] sieRxEp;
    logic [7:0]          sieRxData;
    logic                sieRxReady;
    logic                sieTxReq;
    logic [EP_IDX_W-1:0] sieTxEp;
    logic                sieTxValid;
    logic [7:0]          sieTxData;
    int                  errCount;
    int                  checksDone;

    uefa_endpoint_fifo_access #(.BUF_DEPTH(2)) uut (
        .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sieRxValid(sieRxValid), .sieRxEp(sieRxEp), .sieRxData(sieRxData),
        .sieRxReady(sieRxReady), .sieTxReq(sieTxReq), .sieTxEp(sieTxEp),
        .sieTxValid(sieTxValid), .sieTxData(sieTxData));

    uefa_sie_model sieModel (
        .core_clk(core_clk), .sieRxValid(sieRxValid), .sieRxEp(sieRxEp),
        .sieRxData(sieRxData), .sieRxReady(sieRxReady), .sieTxReq(sieTxReq),
        .sieTxEp(sieTxEp), .sieTxValid(sieTxValid), .sieTxData(sieTxData));

    // ------------------------------------------------------------
    // Clock, checks and expectations
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chkReg(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkBit(input string what, input logic exp, input logic got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Bank capacity worked out independently of the design
    function automatic int expSize(input int ep);
        case (ep)
            0:       return 32;
            1, 2, 3: return 8;
            4, 5:    return 64;
            default: return 128;
        endcase
    endfunction

    // Only seven count bits are visible, so a full bank of 128 reads zero
    function automatic logic [31:0] expCount(input int n);
        return {25'h0, n[6:0]};
    endfunction

    // ------------------------------------------------------------
    // Bus master: one single word transfer, waits on hready
    // ------------------------------------------------------------
    // Waits assume no cycle count; only the watchdog ends a hang
    task automatic busXfer(input logic wr, input logic [7:0] idx, input logic [31:0] wdat,
                           output logic [31:0] rdat);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        haddr  <= {22'h0, idx, 2'b00};
        do begin
            @(posedge core_clk);
        end while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdat;
        do begin
            @(posedge core_clk);
        end while (hreadyout !== 1'b1);
        rdat = hrdata;
        chkBit("bus okay", HRESP_OKAY, hresp);
    endtask

    task automatic regWr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        busXfer(1'b1, idx, d, dummy);
    endtask

    task automatic regRd(input logic [7:0] idx, output logic [31:0] d);
        busXfer(1'b0, idx, 32'h0, d);
    endtask

    // Set-then-clear reset of one endpoint bank
    task automatic resetEp(input int ep);
        regWr(RESET_IDX, 32'h1 << ep);
        regWr(RESET_IDX, 32'h0);
    endtask

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (60000) @(posedge core_clk);
        errCount++;
        $display("BAD watchdog expected finish seen timeout");
        finishTest();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic [7:0]  q[$];
        logic [7:0]  b;
        int          n;
        errCount = 0;
        checksDone = 0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        n = $urandom(61);
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        // Reset values, unmapped place, reserved bit
        regRd(RESET_IDX, rd);
        chkReg("reset reg init", {25'h0, FIFO_RST_INIT}, rd);
        regRd(SELECT_IDX, rd);
        chkReg("select init", {29'h0, SELECT_INIT}, rd);
        regRd(COUNT_IDX, rd);
        chkReg("count init", 32'h0, rd);
        regWr(8'h10, 32'hFFFF_FFFF);
        regRd(8'h10, rd);
        chkReg("unmapped read", 32'h0, rd);
        regWr(RESET_IDX, 32'h0000_007F);
        regRd(RESET_IDX, rd);
        chkReg("reset reg all set", 32'h0000_007F, rd);
        regWr(RESET_IDX, 32'h0);
        // Each endpoint: receive then read, write then transmit, then hold
        for (int ep = 0; ep < 7; ep++) begin
            regWr(SELECT_IDX, ep);
            resetEp(ep);
            n = (ep == 6) ? 128 : 1 + $urandom_range(expSize(ep) - 1);
            q.delete();
            for (int i = 0; i < n; i++) begin
                b = $urandom;
                q.push_back(b);
                sieModel.sendByte(3'(ep), b, $urandom_range(1));
            end
            sieModel.rxRelease();
            repeat (3) @(posedge core_clk);
            regRd(COUNT_IDX, rd);
            chkReg("byte count", expCount(n), rd);
            foreach (q[i]) begin
                regRd(DATA_IDX, rd);
                chkReg("window read", {24'h0, q[i]}, rd);
            end
            resetEp(ep);
            n = 1 + $urandom_range((expSize(ep) > 8) ? 7 : expSize(ep) - 1);
            q.delete();
            for (int i = 0; i < n; i++) begin
                b = $urandom;
                q.push_back(b);
                regWr(DATA_IDX, {24'h0, b});
            end
            foreach (q[i]) begin
                sieModel.fetchByte(3'(ep), b);
                chkReg("engine fetch", {24'h0, q[i]}, {24'h0, b});
            end
            regWr(RESET_IDX, 32'h1 << ep);
            regWr(DATA_IDX, 32'h0000_00C3);
            sieModel.sendByte(3'(ep), 8'hA5, 1'b0);
            sieModel.rxRelease();
            repeat (3) @(posedge core_clk);
            regRd(COUNT_IDX, rd);
            chkReg("held count", 32'h0, rd);
            regRd(DATA_IDX, rd);
            chkReg("held window", 32'h0, rd);
            regWr(RESET_IDX, 32'h0);
            regRd(COUNT_IDX, rd);
            chkReg("count after clear", 32'h0, rd);
        end
        // Nonexistent endpoint: window writes dropped, window and count read zero
        regWr(SELECT_IDX, 32'h7);
        regWr(DATA_IDX, 32'h0000_003C);
        regRd(DATA_IDX, rd);
        chkReg("absent window", 32'h0, rd);
        regRd(COUNT_IDX, rd);
        chkReg("absent count", 32'h0, rd);
        regRd(SELECT_IDX, rd);
        chkReg("select readback", 32'h7, rd);
        // Full bank stalls the buffer; a reset drains it
        regWr(SELECT_IDX, 32'h1);
        resetEp(1);
        for (int i = 0; i < 10; i++) begin
            sieModel.sendByte(3'h1, 8'(i), 1'b0);
        end
        sieModel.rxRelease();
        repeat (3) @(posedge core_clk);
        chkBit("rx ready while full", 1'b0, sieRxReady);
        regWr(RESET_IDX, 32'h2);
        n = 0;
        while (sieRxReady !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        chkBit("rx ready after reset", 1'b1, sieRxReady);
        regWr(RESET_IDX, 32'h0);
        regRd(COUNT_IDX, rd);
        chkReg("count after drain", 32'h0, rd);
        finishTest();
    end
endmodule

`default_nettype wire

//--- verilog/uefa_endpoint_fifo_access.sv
// Endpoint FIFO access block: byte window, byte count, per-endpoint FIFO reset, endpoint select.
// Assumes a single AHB-Lite master and a serial engine synchronous to core_clk.
//
// Decided for this implementation: register access over AHB-Lite.

`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Data window reads and writes go to the FIFO of the selected endpoint.
// - Data window content after reset is undefined; nothing relies on it.
// - Byte count low seven bits give bytes received into the selected endpoint.
// - Bit 7 of byte count and FIFO reset registers always reads zero.
// - Bits 0 to 6 hold endpoints 0 to 6 FIFOs in reset while set.
// - FIFO becomes usable only once software clears its reset bit again.
// - Bit 6 resets endpoint 6, the largest FIFO, like every other bit.
module uefa_endpoint_fifo_access
    import uefa_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = 2
) (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                sieRxValid,
    input  wire logic [EP_IDX_W-1:0] sieRxEp,
    input  wire logic [7:0]          sieRxData,
    output logic                     sieRxReady,
    input  wire logic                sieTxReq,
    input  wire logic [EP_IDX_W-1:0] sieTxEp,
    output logic                     sieTxValid,
    output logic      [7:0]          sieTxData
);

    localparam int unsigned BUF_AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int unsigned BUF_CW = $clog2(BUF_DEPTH + 1);
    localparam logic [BUF_CW-1:0] BUF_FULL = BUF_CW'(BUF_DEPTH);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]          mem [0:EP_COUNT*BANK_DEPTH-1];
    logic [PTR_W-1:0]    wrPtr_q [EP_COUNT];
    logic [PTR_W-1:0]    rdPtr_q [EP_COUNT];
    logic [CNT_W-1:0]    rxCnt_q [EP_COUNT];
    logic [6:0]          fifoRst_q;
    logic [2:0]          select_q;
    logic [7:0]          addr_q;
    logic                wrPend_q;
    logic                rdPend_q;
    logic                hreadyout_q;
    logic [31:0]         hrdata_q;
    logic                sieTxValid_q;
    logic [7:0]          sieTxData_q;
    logic [EP_IDX_W+7:0] buf_q [BUF_DEPTH];
    logic [BUF_AW-1:0]   bufWp_q;
    logic [BUF_AW-1:0]   bufRp_q;
    logic [BUF_CW-1:0]   bufCnt_q;
    logic                sieRxReady_q;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic                accept;
    logic                selOk;
    logic                cpuWr;
    logic                cpuRd;
    logic                headValid;
    logic [EP_IDX_W-1:0] headEp;
    logic [7:0]          headByte;
    logic                headDrop;
    logic                pop;
    logic                push;
    logic                drainWr;
    logic                txServe;
    logic [31:0]         readMux;
    logic [BUF_CW-1:0]   bufCntNext;

    // An endpoint that does not exist counts as held, so its traffic is dropped
    function automatic logic epHeld(input logic [EP_IDX_W-1:0] ep,
                                    input logic [6:0]          rstBits);
        epHeld = (ep >= EP_IDX_W'(EP_COUNT)) ? 1'b1 : rstBits[ep];
    endfunction

    // Bus request and window qualifiers
    assign accept    = hsel && htrans[HTRANS_ACTIVE] && hready;
    assign selOk     = !epHeld(select_q, fifoRst_q);
    assign cpuWr     = wrPend_q && (addr_q == DATA_IDX) && selOk;
    assign cpuRd     = rdPend_q && (addr_q == DATA_IDX) && selOk;

    // Receive buffer head; the CPU owns the memory port first, the engine waits
    assign headValid = (bufCnt_q != '0);
    assign headEp    = buf_q[bufRp_q][EP_IDX_W+7:8];
    assign headByte  = buf_q[bufRp_q][7:0];
    assign headDrop  = epHeld(headEp, fifoRst_q);
    assign pop       = headValid && !cpuWr &&
                       (headDrop || (rxCnt_q[headEp] < epSize(headEp)));
    assign drainWr   = pop && !headDrop;
    assign push      = sieRxValid && sieRxReady_q;
    assign bufCntNext = bufCnt_q + BUF_CW'(push) - BUF_CW'(pop);

    // Transmit reads yield to a CPU read, since both move the read pointer
    assign txServe   = sieTxReq && !cpuRd && !epHeld(sieTxEp, fifoRst_q);

    // Register read multiplexer, sampled in the wait state of a read
    always_comb begin
        readMux = '0;
        case (addr_q)
            DATA_IDX:   readMux[7:0] = selOk ? mem[{select_q, rdPtr_q[select_q]}] : 8'h00;
            COUNT_IDX:  readMux[COUNT_MSB:0] =
                            selOk ? rxCnt_q[select_q][COUNT_MSB:0] : 7'h00;
            RESET_IDX:  readMux[6:0] = fifoRst_q;
            SELECT_IDX: readMux[EP_IDX_W-1:0] = select_q;
            default:    readMux = '0;
        endcase
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Reads take one wait state so a select write just before is already seen
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q      <= 8'h00;
            wrPend_q    <= 1'b0;
            rdPend_q    <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q    <= RDATA_INIT;
        end else if (rdPend_q) begin
            rdPend_q    <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q    <= readMux;
        end else if (accept) begin
            addr_q      <= (haddr[31:IDX_MSB+1] == '0) ? haddr[IDX_MSB:IDX_LSB] : 8'h00;
            wrPend_q    <= hwrite;
            rdPend_q    <= !hwrite;
            hreadyout_q <= hwrite;
        end else begin
            wrPend_q    <= 1'b0;
        end
    end

    // Control registers written in the data phase
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fifoRst_q <= FIFO_RST_INIT;
            select_q  <= SELECT_INIT;
        end else if (wrPend_q) begin
            if (addr_q == RESET_IDX) begin
                fifoRst_q <= hwdata[6:0];
            end
            if (addr_q == SELECT_IDX) begin
                select_q <= hwdata[EP_IDX_W-1:0];
            end
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = HRESP_OKAY;

    // ------------------------------------------------------------
    // Endpoint storage
    // ------------------------------------------------------------
    // No reset on the array: contents are undefined until written
    always_ff @(posedge core_clk) begin
        if (cpuWr) begin
            mem[{select_q, wrPtr_q[select_q]}] <= hwdata[7:0];
        end else if (drainWr) begin
            mem[{headEp, wrPtr_q[headEp]}] <= headByte;
        end
    end

    // Per-endpoint pointers and received count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int e = 0; e < EP_COUNT; e++) begin
                wrPtr_q[e] <= '0;
                rdPtr_q[e] <= '0;
                rxCnt_q[e] <= '0;
            end
        end else begin
            for (int e = 0; e < EP_COUNT; e++) begin
                if (fifoRst_q[e]) begin
                    // Held until software clears the bit
                    wrPtr_q[e] <= '0;
                    rdPtr_q[e] <= '0;
                    rxCnt_q[e] <= '0;
                end else begin
                    if ((cpuWr && select_q == EP_IDX_W'(e)) ||
                        (drainWr && headEp == EP_IDX_W'(e))) begin
                        wrPtr_q[e] <= ptrStep(EP_IDX_W'(e), wrPtr_q[e]);
                    end
                    if (drainWr && headEp == EP_IDX_W'(e)) begin
                        rxCnt_q[e] <= rxCnt_q[e] + 8'h01;
                    end
                    if ((cpuRd && select_q == EP_IDX_W'(e)) ||
                        (txServe && sieTxEp == EP_IDX_W'(e))) begin
                        rdPtr_q[e] <= ptrStep(EP_IDX_W'(e), rdPtr_q[e]);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Engine side: receive buffer and transmit read
    // ------------------------------------------------------------
    // Two-entry buffer; ready is registered, so it looks at the next count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bufWp_q      <= '0;
            bufRp_q      <= '0;
            bufCnt_q     <= '0;
            sieRxReady_q <= 1'b0;
        end else begin
            if (push) begin
                bufWp_q <= (bufWp_q == BUF_AW'(BUF_DEPTH - 1)) ? '0 : bufWp_q + 1'b1;
            end
            if (pop) begin
                bufRp_q <= (bufRp_q == BUF_AW'(BUF_DEPTH - 1)) ? '0 : bufRp_q + 1'b1;
            end
            bufCnt_q     <= bufCntNext;
            sieRxReady_q <= (bufCntNext < BUF_FULL);
        end
    end

    // Buffer entries need no reset; count guards them
    always_ff @(posedge core_clk) begin
        if (push) begin
            buf_q[bufWp_q] <= {sieRxEp, sieRxData};
        end
    end

    // One byte per request, answered on the next cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sieTxValid_q <= 1'b0;
            sieTxData_q  <= 8'h00;
        end else begin
            sieTxValid_q <= txServe;
            if (txServe) begin
                sieTxData_q <= mem[{sieTxEp, rdPtr_q[sieTxEp]}];
            end
        end
    end

    assign sieRxReady = sieRxReady_q;
    assign sieTxValid = sieTxValid_q;
    assign sieTxData  = sieTxData_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic [MEM_AW-1:0] wrAddrHelp;
    logic [7:0]        wrByteHelp;
    logic [PTR_W-1:0]  rdPtrSel;
    logic [PTR_W-1:0]  rdPtrSelNext;
    logic [6:0]        cntSel;
    logic              heldWr;
    assign wrAddrHelp   = {select_q, wrPtr_q[select_q]};
    assign wrByteHelp   = hwdata[7:0];
    assign rdPtrSel     = selOk ? rdPtr_q[select_q] : '0;
    assign rdPtrSelNext = ptrStep(select_q, rdPtrSel);
    assign cntSel       = selOk ? rxCnt_q[select_q][COUNT_MSB:0] : '0;
    assign heldWr       = wrPend_q && (addr_q == DATA_IDX) && !selOk;

    property p_window_route;
        cpuWr |=> mem[$past(wrAddrHelp)] == $past(wrByteHelp);
    endproperty
    a_window_route: assert property (p_window_route)
        else $error("window write missed the selected endpoint");

    property p_count_read;
        (rdPend_q && addr_q == COUNT_IDX) |=> hrdata_q[COUNT_MSB:0] == $past(cntSel);
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("byte count read wrong");

    property p_reserved_zero;
        (rdPend_q && (addr_q == COUNT_IDX || addr_q == RESET_IDX))
            |=> hrdata_q[RSVD_BIT] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read nonzero");

    property p_held_zero;
        fifoRst_q[0] |=> (rxCnt_q[0] == '0 && wrPtr_q[0] == '0 && rdPtr_q[0] == '0);
    endproperty
    a_held_zero: assert property (p_held_zero)
        else $error("held endpoint zero not cleared");

    property p_held_write;
        heldWr |=> $stable(hrdata_q) && !$past(cpuWr);
    endproperty
    a_held_write: assert property (p_held_write)
        else $error("held endpoint took a window write");

    property p_ep_six;
        $fell(fifoRst_q[6]) |-> (wrPtr_q[6] == '0 && rdPtr_q[6] == '0 && rxCnt_q[6] == '0);
    endproperty
    a_ep_six: assert property (p_ep_six)
        else $error("endpoint six not cleared by its bit");

    property p_read_step;
        cpuRd |=> rdPtrSel == $past(rdPtrSelNext);
    endproperty
    a_read_step: assert property (p_read_step)
        else $error("read did not advance pointer by one");

    property p_read_wait;
        (accept && !hwrite && !rdPend_q) |=> !hreadyout_q ##1 hreadyout_q;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");

    property p_buf_bound;
        push |-> bufCnt_q < BUF_FULL;
    endproperty
    a_buf_bound: assert property (p_buf_bound)
        else $error("receive buffer overflow");

    c_rx_stall:  cover property (!sieRxReady_q ##1 sieRxReady_q);
    c_reset_use: cover property ($fell(fifoRst_q[6]) ##[1:50] cpuWr);
    c_count_rd:  cover property (rdPend_q && addr_q == COUNT_IDX && cntSel != '0);
    c_tx_serve:  cover property (txServe ##1 txServe);

endmodule

`default_nettype wire

//--- verilog/uefa_pkg.sv
// Constants, register indices and endpoint geometry for the endpoint FIFO access block.
// Assumes a 32-bit AHB-Lite slave port with every register on one aligned word.

package uefa_pkg;

    // ------------------------------------------------------------
    // Endpoint geometry
    // ------------------------------------------------------------
    localparam int unsigned EP_COUNT   = 7;
    localparam int unsigned EP_IDX_W   = 3;
    localparam int unsigned PTR_W      = 7;
    localparam int unsigned CNT_W      = 8;
    localparam int unsigned BANK_DEPTH = 128;
    localparam int unsigned MEM_AW     = EP_IDX_W + PTR_W;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_IDX   = 8'hCF;
    localparam logic [7:0] COUNT_IDX  = 8'hE2;
    localparam logic [7:0] RESET_IDX  = 8'hD5;
    localparam logic [7:0] SELECT_IDX = 8'hC7;
    localparam int unsigned IDX_LSB   = 2;
    localparam int unsigned IDX_MSB   = 9;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned RSVD_BIT      = 7;
    localparam int unsigned COUNT_MSB     = 6;
    localparam int unsigned HTRANS_ACTIVE = 1;
    localparam logic        HRESP_OKAY    = 1'b0;
    localparam logic [6:0]  FIFO_RST_INIT = 7'h00;
    localparam logic [2:0]  SELECT_INIT   = 3'h0;
    localparam logic [31:0] RDATA_INIT    = 32'h0000_0000;

    // Capacity of each endpoint bank in bytes
    function automatic logic [CNT_W-1:0] epSize(input logic [EP_IDX_W-1:0] ep);
        case (ep)
            3'h0:    epSize = 8'h20;
            3'h1,
            3'h2,
            3'h3:    epSize = 8'h08;
            3'h4,
            3'h5:    epSize = 8'h40;
            default: epSize = 8'h80;
        endcase
    endfunction

    // Byte pointer step with wrap at the bank size
    function automatic logic [PTR_W-1:0] ptrStep(input logic [EP_IDX_W-1:0] ep,
                                                 input logic [PTR_W-1:0]    ptr);
        logic [CNT_W-1:0] nxt;
        nxt = {1'b0, ptr} + 8'h01;
        ptrStep = (nxt == epSize(ep)) ? 7'h00 : nxt[PTR_W-1:0];
    endfunction

endpackage
